/* File: lbp_pkg.sv */
// Shared constants and types of the LED blink pattern register bank.
// Assumes a 10 MHz system clock and a link front end that delivers whole bytes.
package lbp_pkg;

	// Register indices selected by the low four command bits.
	localparam logic [3:0] IDX_STATE_LOW  = 4'h0;
	localparam logic [3:0] IDX_STATE_MID  = 4'h1;
	localparam logic [3:0] IDX_STATE_HIGH = 4'h2;
	localparam logic [3:0] IDX_RAMP_UP    = 4'h3;
	localparam logic [3:0] IDX_PEAK_HOLD  = 4'h4;
	localparam logic [3:0] IDX_RAMP_DOWN  = 4'h5;
	localparam logic [3:0] IDX_DARK_ONE   = 4'h6;
	localparam logic [3:0] IDX_DARK_TWO   = 4'h7;
	localparam logic [3:0] IDX_PEAK_LEVEL = 4'h8;
	localparam logic [3:0] IDX_MASTER     = 4'h9;
	localparam logic [3:0] IDX_START      = 4'hA;

	// Values after reset.
	localparam logic [7:0] RST_STATE  = 8'h00;
	localparam logic [7:0] RST_TIME   = 8'h44;
	localparam logic [7:0] RST_PEAK   = 8'hFF;
	localparam logic [7:0] RST_MASTER = 8'h0F;
	localparam logic [3:0] RST_INDEX  = 4'h0;

	// Field positions and pin count.
	localparam int INDEX_ADVANCE_BIT = 4;
	localparam int LEVEL_SRC0_BIT    = 4;
	localparam int LEVEL_SRC1_BIT    = 5;
	localparam int START_GO0_BIT     = 3;
	localparam int START_GO1_BIT     = 7;
	localparam int LED_COUNT         = 7;

	// Refresh frame and intensity steps.
	localparam int unsigned FRAME_MS    = 8;
	localparam int unsigned SYS_CLK_KHZ = 10000;
	localparam int unsigned LEVEL_STEPS = 15;
	localparam logic [3:0]  LEVEL_FULL  = 4'hF;
	localparam logic [3:0]  LEVEL_ZERO  = 4'h0;

	// Duration code to milliseconds; every entry is a whole number of frames.
	localparam int unsigned DUR_MS [16] = '{0, 64, 128, 192, 256, 384, 512, 768,
		1024, 1536, 2048, 3072, 4096, 5760, 8128, 16320};

	// Blink cycle phases, in the order of the start point field.
	typedef enum logic [2:0] {
		PH_RISE_ONE, PH_HOLD_ONE, PH_FALL_ONE, PH_DARK_ONE,
		PH_RISE_TWO, PH_HOLD_TWO, PH_FALL_TWO, PH_DARK_TWO
	} lbp_phase_t;

	typedef enum logic [1:0] {
		KIND_CMD, KIND_WR, KIND_RD
	} lbp_kind_t;

endpackage

/* File: lbp_toggle_sync.sv */
// Carries a toggle event into another clock domain as a one-cycle pulse.
// Assumes the source toggles at most once per completed handshake.
`timescale 1ns/1ps
module lbp_toggle_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic tgl_i,
	output logic      level_o,
	output logic      pulse_o
);
	logic meta;
	logic seen;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta    <= 1'b0;
			level_o <= 1'b0;
			seen    <= 1'b0;
		end else begin
			meta    <= tgl_i;
			level_o <= meta;
			seen    <= level_o;
		end
	end

	assign pulse_o = level_o ^ seen;
endmodule

/* File: lbp_pattern_unit.sv */
// One pattern unit: the double-pulse blink waveform, stepped once per frame.
// Assumes frame_tick_i pulses once per refresh frame on the same clock.
`timescale 1ns/1ps
module lbp_pattern_unit
	import lbp_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       frame_tick_i,
	input  wire logic [3:0] rise_code_i,
	input  wire logic [3:0] hold_code_i,
	input  wire logic [3:0] fall_code_i,
	input  wire logic [3:0] dark_one_code_i,
	input  wire logic [3:0] dark_two_code_i,
	input  wire logic [3:0] peak_i,
	input  wire logic       start_i,
	input  wire logic [2:0] start_phase_i,
	output logic [3:0]      level_o
);
	lbp_phase_t  phase;
	logic [10:0] elapsed;
	logic [10:0] span;
	logic [3:0]  code;
	logic [14:0] scaled;

	function automatic logic [10:0] lbp_frames(input logic [3:0] c);
		lbp_frames = 11'(DUR_MS[c] / FRAME_MS);
	endfunction

	// Both pulses share rise, hold and fall; the dark times differ.
	always_comb begin
		case (phase)
			PH_RISE_ONE, PH_RISE_TWO: code = rise_code_i;
			PH_HOLD_ONE, PH_HOLD_TWO: code = hold_code_i;
			PH_FALL_ONE, PH_FALL_TWO: code = fall_code_i;
			PH_DARK_ONE:              code = dark_one_code_i;
			default:                  code = dark_two_code_i;
		endcase
		span = lbp_frames(code);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			phase   <= PH_RISE_ONE;
			elapsed <= 11'h000;
		end else if (start_i) begin
			phase   <= lbp_phase_t'(start_phase_i);
			elapsed <= 11'h000;
		end else if (frame_tick_i) begin
			if (elapsed + 11'h001 >= span) begin
				phase   <= lbp_phase_t'(3'(phase + 3'h1));
				elapsed <= 11'h000;
			end else begin
				elapsed <= elapsed + 11'h001;
			end
		end
	end

	// Ramps are linear here; a perceptual curve would replace the scaling.
	always_comb begin
		case (phase)
			PH_RISE_ONE, PH_RISE_TWO: scaled = 15'(peak_i * elapsed);
			PH_FALL_ONE, PH_FALL_TWO: scaled = 15'(peak_i * (span - elapsed));
			default:                  scaled = 15'h0000;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			level_o <= LEVEL_ZERO;
		end else if (phase == PH_HOLD_ONE || phase == PH_HOLD_TWO) begin
			level_o <= peak_i;
		end else if (span == 11'h000) begin
			level_o <= LEVEL_ZERO;
		end else begin
			level_o <= 4'(scaled / 15'(span));
		end
	end
endmodule

/* File: lbp_led_regs.sv */
// Top of the LED blink pattern block: register bank, link crossing and pin decode.
// Assumes a link front end on link_clk_i that hands over whole command and data bytes.
`timescale 1ns/1ps
module lbp_led_regs
	import lbp_pkg::*;
#(
	parameter int unsigned REFRESH_CYC = FRAME_MS * SYS_CLK_KHZ
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 link_clk_i,
	input  wire logic                 link_cmd_i,
	input  wire logic                 link_wr_i,
	input  wire logic                 link_rd_i,
	input  wire logic [7:0]           link_byte_i,
	output logic                      link_busy_o,
	output logic [7:0]                link_rd_data_o,
	output logic                      link_rd_valid_o,
	output logic [LED_COUNT-1:0]      led_out_o,
	output logic [LED_COUNT-1:0]      led_oe_n_o
);
	localparam int CNT_W = $clog2(REFRESH_CYC);
	localparam int unsigned SLOT_CYC = REFRESH_CYC / LEVEL_STEPS;

	// Register bank.
	logic [7:0] output_state_low_bits;
	logic [7:0] output_state_mid_bits;
	logic [7:0] output_state_high_bits;
	logic [7:0] ramp_up_time;
	logic [7:0] peak_hold_time;
	logic [7:0] ramp_down_time;
	logic [7:0] first_dark_time;
	logic [7:0] second_dark_time;
	logic [7:0] unit_peak_level;
	logic [7:0] single_shot_and_master_level;
	logic [3:0] reg_index;
	logic       index_advance_bit;

	// Link domain.
	logic       link_rst_meta;
	logic       link_rst;
	logic       req_tgl;
	lbp_kind_t  req_kind;
	logic [7:0] req_byte;
	logic       ack_level;
	logic       ack_pulse;

	// System domain.
	logic       req_pulse;
	logic       ack_tgl;
	logic [7:0] rd_data;
	logic [7:0] next_rd_data;
	logic       start_wr;
	logic [CNT_W-1:0] frame_cnt;
	logic       frame_tick;
	logic [3:0] master_level;
	logic [3:0] level_zero;
	logic [3:0] level_one;
	logic [3:0] wave_zero;
	logic [3:0] wave_one;
	logic [LED_COUNT-1:0] next_oe_n;

	// Reset reaches the link logic through two link-clock stages.
	always_ff @(posedge link_clk_i) begin
		link_rst_meta <= rst_i;
		link_rst      <= link_rst_meta;
	end

	// A strobe is taken only while no earlier byte is still in flight.
	assign link_busy_o = req_tgl ^ ack_level;

	// The held kind and byte stay still until the acknowledge returns.
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			req_tgl  <= 1'b0;
			req_kind <= KIND_CMD;
			req_byte <= 8'h00;
		end else if (!link_busy_o && (link_cmd_i || link_wr_i || link_rd_i)) begin
			req_tgl  <= ~req_tgl;
			req_byte <= link_byte_i;
			if (link_cmd_i) begin
				req_kind <= KIND_CMD;
			end else if (link_wr_i) begin
				req_kind <= KIND_WR;
			end else begin
				req_kind <= KIND_RD;
			end
		end
	end

	lbp_toggle_sync u_req_sync (
		.clk_i   (sys_clk_i),
		.rst_i   (rst_i),
		.tgl_i   (req_tgl),
		.level_o (),
		.pulse_o (req_pulse)
	);

	lbp_toggle_sync u_ack_sync (
		.clk_i   (link_clk_i),
		.rst_i   (link_rst),
		.tgl_i   (ack_tgl),
		.level_o (ack_level),
		.pulse_o (ack_pulse)
	);

	// Read data is stable in the system domain from the acknowledge onward.
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			link_rd_data_o  <= 8'h00;
			link_rd_valid_o <= 1'b0;
		end else begin
			link_rd_valid_o <= ack_pulse && (req_kind == KIND_RD);
			if (ack_pulse && req_kind == KIND_RD) begin
				link_rd_data_o <= rd_data;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ack_tgl <= 1'b0;
		end else if (req_pulse) begin
			ack_tgl <= ~ack_tgl;
		end
	end

	// Command bytes set the index; data bytes may advance it.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_index         <= RST_INDEX;
			index_advance_bit <= 1'b0;
		end else if (req_pulse && req_kind == KIND_CMD) begin
			reg_index         <= req_byte[3:0];
			index_advance_bit <= req_byte[INDEX_ADVANCE_BIT];
		end else if (req_pulse && req_kind == KIND_WR && index_advance_bit) begin
			if (reg_index == IDX_START) begin
				reg_index <= RST_INDEX;
			end else begin
				reg_index <= reg_index + 4'h1;
			end
		end
	end

	// Register writes; indices above the start register are not decoded.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			output_state_low_bits        <= RST_STATE;
			output_state_mid_bits        <= RST_STATE;
			output_state_high_bits       <= RST_STATE;
			ramp_up_time                 <= RST_TIME;
			peak_hold_time               <= RST_TIME;
			ramp_down_time               <= RST_TIME;
			first_dark_time              <= RST_TIME;
			second_dark_time             <= RST_TIME;
			unit_peak_level              <= RST_PEAK;
			single_shot_and_master_level <= RST_MASTER;
		end else if (req_pulse && req_kind == KIND_WR) begin
			if (reg_index == IDX_STATE_LOW) begin
				output_state_low_bits <= req_byte;
			end else if (reg_index == IDX_STATE_MID) begin
				output_state_mid_bits <= req_byte;
			end else if (reg_index == IDX_STATE_HIGH) begin
				output_state_high_bits <= req_byte;
			end else if (reg_index == IDX_RAMP_UP) begin
				ramp_up_time <= req_byte;
			end else if (reg_index == IDX_PEAK_HOLD) begin
				peak_hold_time <= req_byte;
			end else if (reg_index == IDX_RAMP_DOWN) begin
				ramp_down_time <= req_byte;
			end else if (reg_index == IDX_DARK_ONE) begin
				first_dark_time <= req_byte;
			end else if (reg_index == IDX_DARK_TWO) begin
				second_dark_time <= req_byte;
			end else if (reg_index == IDX_PEAK_LEVEL) begin
				unit_peak_level <= req_byte;
			end else if (reg_index == IDX_MASTER) begin
				single_shot_and_master_level <= req_byte;
			end
		end
	end

	// The start register is not stored; a write restarts the chosen units.
	assign start_wr = req_pulse && req_kind == KIND_WR && reg_index == IDX_START;

	// Read answer, captured when a read request arrives.
	always_comb begin
		if (reg_index == IDX_STATE_LOW) begin
			next_rd_data = output_state_low_bits;
		end else if (reg_index == IDX_STATE_MID) begin
			next_rd_data = output_state_mid_bits;
		end else if (reg_index == IDX_STATE_HIGH) begin
			next_rd_data = output_state_high_bits;
		end else if (reg_index == IDX_RAMP_UP) begin
			next_rd_data = ramp_up_time;
		end else if (reg_index == IDX_PEAK_HOLD) begin
			next_rd_data = peak_hold_time;
		end else if (reg_index == IDX_RAMP_DOWN) begin
			next_rd_data = ramp_down_time;
		end else if (reg_index == IDX_DARK_ONE) begin
			next_rd_data = first_dark_time;
		end else if (reg_index == IDX_DARK_TWO) begin
			next_rd_data = second_dark_time;
		end else if (reg_index == IDX_PEAK_LEVEL) begin
			next_rd_data = unit_peak_level;
		end else if (reg_index == IDX_MASTER) begin
			next_rd_data = single_shot_and_master_level;
		end else begin
			next_rd_data = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_data <= 8'h00;
		end else if (req_pulse && req_kind == KIND_RD) begin
			rd_data <= next_rd_data;
		end
	end

	// Refresh frame: pattern units step and the lit window is laid out once per frame.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			frame_cnt <= '0;
		end else if (frame_tick) begin
			frame_cnt <= '0;
		end else begin
			frame_cnt <= frame_cnt + CNT_W'(1);
		end
	end

	assign frame_tick = (frame_cnt == CNT_W'(REFRESH_CYC - 1));

	// Each unit's peak comes from its own field or from the master level.
	assign master_level = single_shot_and_master_level[3:0];
	assign level_zero = single_shot_and_master_level[LEVEL_SRC0_BIT] ?
		master_level : unit_peak_level[3:0];
	assign level_one = single_shot_and_master_level[LEVEL_SRC1_BIT] ?
		master_level : unit_peak_level[7:4];

	lbp_pattern_unit u_unit_zero (
		.sys_clk_i       (sys_clk_i),
		.rst_i           (rst_i),
		.frame_tick_i    (frame_tick),
		.rise_code_i     (ramp_up_time[3:0]),
		.hold_code_i     (peak_hold_time[3:0]),
		.fall_code_i     (ramp_down_time[3:0]),
		.dark_one_code_i (first_dark_time[3:0]),
		.dark_two_code_i (second_dark_time[3:0]),
		.peak_i          (level_zero),
		.start_i         (start_wr && req_byte[START_GO0_BIT]),
		.start_phase_i   (req_byte[2:0]),
		.level_o         (wave_zero)
	);

	lbp_pattern_unit u_unit_one (
		.sys_clk_i       (sys_clk_i),
		.rst_i           (rst_i),
		.frame_tick_i    (frame_tick),
		.rise_code_i     (ramp_up_time[7:4]),
		.hold_code_i     (peak_hold_time[7:4]),
		.fall_code_i     (ramp_down_time[7:4]),
		.dark_one_code_i (first_dark_time[7:4]),
		.dark_two_code_i (second_dark_time[7:4]),
		.peak_i          (level_one),
		.start_i         (start_wr && req_byte[START_GO1_BIT]),
		.start_phase_i   (req_byte[6:4]),
		.level_o         (wave_one)
	);

	// Level 15 stays lit the whole frame; the slot width truncates for lower levels.
	function automatic logic lbp_lit(input logic [3:0] lvl, input logic [CNT_W-1:0] pos);
		lbp_lit = (lvl == LEVEL_FULL) || (32'(pos) < 32'(lvl) * SLOT_CYC);
	endfunction

	// Per-pin decode of the three state bits; bit 7 is never looked at.
	genvar g;
	generate
		for (g = 0; g < LED_COUNT; g++) begin : g_pin
			always_comb begin
				case ({output_state_high_bits[g], output_state_mid_bits[g],
					output_state_low_bits[g]})
					3'b000, 3'b001: next_oe_n[g] = 1'b1;
					3'b010:         next_oe_n[g] = !lbp_lit(level_zero, frame_cnt);
					3'b011:         next_oe_n[g] = !lbp_lit(level_one, frame_cnt);
					3'b100:         next_oe_n[g] = 1'b0;
					3'b101:         next_oe_n[g] = !lbp_lit(master_level, frame_cnt);
					3'b110:         next_oe_n[g] = !lbp_lit(wave_zero, frame_cnt);
					default:        next_oe_n[g] = !lbp_lit(wave_one, frame_cnt);
				endcase
			end
		end
	endgenerate

	// Pins are open drain: the driven value is always low, only the enable moves.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			led_oe_n_o <= '1;
			led_out_o  <= '0;
		end else begin
			led_oe_n_o <= next_oe_n;
			led_out_o  <= '0;
		end
	end
endmodule

/* File: lbp_led_regs_sva.sv */
// Checker for the LED blink pattern top: link handshake, read answers and pin drive.
// Assumes it is bound to lbp_led_regs and sees only the ports of that module.
`timescale 1ns/1ps
module lbp_led_regs_sva
	import lbp_pkg::*;
#(
	parameter int unsigned REFRESH_CYC = 150
) (
	input wire logic                 sys_clk_i,
	input wire logic                 rst_i,
	input wire logic                 link_clk_i,
	input wire logic                 link_cmd_i,
	input wire logic                 link_wr_i,
	input wire logic                 link_rd_i,
	input wire logic [7:0]           link_byte_i,
	input wire logic                 link_busy_o,
	input wire logic [7:0]           link_rd_data_o,
	input wire logic                 link_rd_valid_o,
	input wire logic [LED_COUNT-1:0] led_out_o,
	input wire logic [LED_COUNT-1:0] led_oe_n_o
);
	logic       take;
	logic [3:0] idx;
	logic       adv;
	logic       zero_rd;

	assign take = (link_cmd_i || link_wr_i || link_rd_i) && !link_busy_o;

	// Shadow index, so that answers from unmapped places can be judged at the ports.
	always_ff @(posedge link_clk_i) begin
		if (rst_i) begin
			idx     <= 4'h0;
			adv     <= 1'b0;
			zero_rd <= 1'b0;
		end else if (take && link_cmd_i) begin
			idx <= link_byte_i[3:0];
			adv <= link_byte_i[INDEX_ADVANCE_BIT];
		end else if (take && link_wr_i && adv) begin
			idx <= (idx == 4'hA || idx == 4'hF) ? 4'h0 : idx + 4'h1;
		end else if (take && link_rd_i) begin
			zero_rd <= idx >= 4'hA;
		end
	end

	pin_drive_zero_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i) led_out_o == '0)
		else $error("Pin drive value is not zero.");
	reset_released_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i) $fell(rst_i) |-> led_oe_n_o == 7'h7F)
		else $error("Pins not released after reset.");
	take_busy_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) take |=> link_busy_o)
		else $error("Busy did not follow a taken byte.");
	busy_bound_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) $rose(link_busy_o) |-> ##[1:10] !link_busy_o)
		else $error("Busy held too long.");
	busy_cause_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) $rose(link_busy_o) |-> $past(take))
		else $error("Busy rose without a taken byte.");
	valid_pulse_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) link_rd_valid_o |=> !link_rd_valid_o)
		else $error("Read valid longer than one cycle.");
	valid_after_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) link_rd_valid_o |->
		!link_busy_o && ($past(link_busy_o) || $past(link_busy_o, 2)))
		else $error("Read valid not just after busy.");
	data_hold_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) !link_rd_valid_o |-> $stable(link_rd_data_o))
		else $error("Read data moved without valid.");
	unmapped_zero_a: assert property (
		@(posedge link_clk_i) disable iff (rst_i) link_rd_valid_o && zero_rd |->
		link_rd_data_o == 8'h00)
		else $error("Unmapped read not zero.");
endmodule

bind lbp_led_regs lbp_led_regs_sva #(.REFRESH_CYC(REFRESH_CYC)) u_sva (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
	.link_cmd_i(link_cmd_i), .link_wr_i(link_wr_i), .link_rd_i(link_rd_i),
	.link_byte_i(link_byte_i), .link_busy_o(link_busy_o),
	.link_rd_data_o(link_rd_data_o), .link_rd_valid_o(link_rd_valid_o),
	.led_out_o(led_out_o), .led_oe_n_o(led_oe_n_o));

/* File: lbp_link_host.sv */
// Host model on the link side: hands over one byte at a time.
// Assumes it is called at a rising edge of the link clock.
`timescale 1ns/1ps
module lbp_link_host
	import lbp_pkg::*;
(
	input  wire logic       link_clk_i,
	input  wire logic       busy_i,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i,
	output logic            cmd_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic [7:0]      byte_o
);
	logic tmo = 1'b0;

	initial begin
		cmd_o  = 1'b0;
		wr_o   = 1'b0;
		rd_o   = 1'b0;
		byte_o = 8'h00;
	end

	task automatic xfer(input lbp_kind_t k, input logic [7:0] b, output logic [7:0] q);
		int   n;
		logic seen;
		n    = 0;
		seen = 1'b0;
		repeat ($urandom % 3) @(posedge link_clk_i);
		cmd_o  <= k == KIND_CMD;
		wr_o   <= k == KIND_WR;
		rd_o   <= k == KIND_RD;
		byte_o <= b;
		@(posedge link_clk_i);
		cmd_o <= 1'b0;
		wr_o  <= 1'b0;
		rd_o  <= 1'b0;
		// A stale byte would hide a sampling slip, so the line shows its inverse.
		byte_o <= ~b;
		do begin
			@(posedge link_clk_i);
			seen = seen | busy_i;
			n++;
		end while (!(k == KIND_RD ? rd_valid_i : seen && !busy_i) && n < 64);
		q = rd_data_i;
		if (n >= 64) tmo = 1'b1;
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the LED blink pattern register bank.
// Assumes the design, its checker and the link host model are compiled first.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
	$display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end
module tb;
	import lbp_pkg::*;

	localparam int unsigned RCYC = 150;
	localparam int unsigned SLOT = RCYC / 15;

	logic                 sys_clk_i = 1'b0;
	logic                 link_clk  = 1'b0;
	logic                 rst_i     = 1'b1;
	logic                 cmd;
	logic                 wr;
	logic                 rd;
	logic [7:0]           lbyte;
	logic                 busy;
	logic                 rd_valid;
	logic [7:0]           rd_data;
	logic [LED_COUNT-1:0] led_out;
	logic [LED_COUNT-1:0] led_oe_n;
	logic [7:0]           shadow [16];
	logic [7:0]           q;
	int                   err_count = 0;
	int                   n_tests   = 0;

	initial forever #50 sys_clk_i = ~sys_clk_i;
	initial begin
		#13;
		forever #40 link_clk = ~link_clk;
	end

	lbp_led_regs #(.REFRESH_CYC(RCYC)) u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.link_clk_i(link_clk), .link_cmd_i(cmd), .link_wr_i(wr), .link_rd_i(rd),
		.link_byte_i(lbyte), .link_busy_o(busy), .link_rd_data_o(rd_data),
		.link_rd_valid_o(rd_valid), .led_out_o(led_out), .led_oe_n_o(led_oe_n));
	lbp_link_host u_host (.link_clk_i(link_clk), .busy_i(busy), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid), .cmd_o(cmd), .wr_o(wr), .rd_o(rd), .byte_o(lbyte));

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic xfer(input lbp_kind_t k, input logic [7:0] b);
		u_host.xfer(k, b, q);
		if (u_host.tmo) begin
			err_count++;
			results();
		end
	endtask

	task automatic wreg(input logic [3:0] i, input logic [7:0] v);
		xfer(KIND_CMD, {4'h0, i});
		xfer(KIND_WR, v);
		if (i < IDX_START) shadow[i] = v;
	endtask

	task automatic rreg(input logic [3:0] i);
		xfer(KIND_CMD, {4'h0, i});
		xfer(KIND_RD, 8'h00);
	endtask

	function automatic logic [7:0] rst_val(logic [3:0] i);
		if (i <= IDX_STATE_HIGH) return RST_STATE;
		if (i <= IDX_DARK_TWO) return RST_TIME;
		if (i == IDX_PEAK_LEVEL) return RST_PEAK;
		if (i == IDX_MASTER) return RST_MASTER;
		return 8'h00;
	endfunction

	// Lit cycles per frame; for blinking codes this is an upper bound.
	function automatic int unsigned lit(logic [2:0] c, logic [7:0] pk, logic [7:0] ms);
		logic [3:0] u0;
		logic [3:0] u1;
		u0 = ms[LEVEL_SRC0_BIT] ? ms[3:0] : pk[3:0];
		u1 = ms[LEVEL_SRC1_BIT] ? ms[3:0] : pk[7:4];
		case (c)
			3'h2, 3'h6: return u0 * SLOT;
			3'h3, 3'h7: return u1 * SLOT;
			3'h4: return RCYC;
			3'h5: return ms[3:0] * SLOT;
			default: return 0;
		endcase
	endfunction

	initial begin
		int unsigned cnt [LED_COUNT];
		logic [7:0]  pk;
		logic [7:0]  ms;
		logic [7:0]  lo;
		logic [7:0]  mi;
		logic [7:0]  hi;
		logic [2:0]  c;
		void'($urandom(51));
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge link_clk);
		for (int i = 0; i < 16; i++) begin
			rreg(i[3:0]);
			shadow[i] = rst_val(i[3:0]);
			`CHK("reset value", shadow[i], q)
		end
		$display("Test reset values done");
		for (int i = 0; i < 16; i++) wreg(i[3:0], 8'($urandom));
		for (int i = 0; i < 16; i++) begin
			rreg(i[3:0]);
			`CHK("readback", shadow[i], q)
		end
		$display("Test random readback done");
		xfer(KIND_CMD, 8'h13);
		for (int i = 3; i <= 11; i++) begin
			pk = 8'($urandom);
			xfer(KIND_WR, pk);
			if (i < 10) shadow[i] = pk;
			else if (i == 11) shadow[0] = pk;
		end
		for (int i = 0; i < 10; i++) begin
			rreg(i[3:0]);
			`CHK("advance write", shadow[i], q)
		end
		$display("Test index advance done");
		for (int r = 0; r < 2; r++) begin
			pk = 8'($urandom);
			ms = {2'h0, r[0], r[0], 4'($urandom)};
			lo = {r[0], 7'h00};
			mi = lo;
			hi = lo;
			for (int p = 0; p < LED_COUNT; p++) begin
				c = 3'(p + r);
				{hi[p], mi[p], lo[p]} = c;
			end
			wreg(IDX_PEAK_LEVEL, pk);
			wreg(IDX_MASTER, ms);
			xfer(KIND_CMD, 8'h10);
			xfer(KIND_WR, lo);
			xfer(KIND_WR, mi);
			xfer(KIND_WR, hi);
			repeat (2 * RCYC) @(posedge sys_clk_i);
			cnt = '{default: 0};
			repeat (RCYC) begin
				@(posedge sys_clk_i);
				for (int p = 0; p < LED_COUNT; p++) cnt[p] += !led_oe_n[p];
			end
			for (int p = 0; p < LED_COUNT; p++) begin
				c = 3'(p + r);
				if (c[2] && c[1]) begin
					`CHK("blink bound", 1'b1, cnt[p] <= lit(c, pk, ms))
				end else begin
					`CHK("pin duty", lit(c, pk, ms), cnt[p])
				end
			end
			`CHK("pin drive", 7'h00, led_out)
			$display("Test pin decode round %0d done", r);
		end
		results();
	end
endmodule
